// ==== src/asp_block.sv ====
// ASK slope divider and PA block selection register bank with Avalon-MM slave
// Summary of operation
// [RQ1] Divider low eight bits live in bits 7:0 of first shaping register
// [RQ2] Divider bits 9:8 live in bits 1:0 of PA configuration register
// [RQ3] Divider divides by programmed value plus one, range 1 to 1024
// [RQ4] Divided clock paces PA stage switching, setting keying slope
// [RQ5] Each select bit enables its PA block; bit n controls block n
// [RQ6] Combined ten-bit value sets shaping clock frequency
// [RQ7] Reloading counter emits one tick per expiry, advancing stage sequence
`timescale 1ns/1ps
`default_nettype none
module asp_block #(
	parameter int STEPS = 12
) (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        ask_data_i,
	output logic [2:0]       pa_block_en_a_o,
	output logic [2:0]       pa_block_en_b_o,
	output logic             slope_tick_o,
	output logic [3:0]       pa_stage_step_o
);
	// Notes for the next engineer:
	// The two configuration registers are kept readable so software can
	// check what it programmed; a status word at its own index shows the
	// ratio low byte, the ramp activity, the current step and the level.
	// The divider counter runs free from reset. A new ratio is only picked
	// up at the next reload, so a change of ratio never cuts a period short
	// and never produces a runt tick. The cost is up to one old period of
	// latency before the new slope is in force.
	// Writing the ratio takes two bus writes; between them the counter may
	// reload once from a half-updated ratio. Software that cares should
	// write the low byte first and the high byte last.
	// The keying input is asynchronous; it passes three flops and a new
	// level is accepted only once the last two agree, which rejects a
	// single-cycle glitch on the pin.

	// Registered state and its next value
	asp_pkg::asp_state_s       st_r;
	asp_pkg::asp_state_s       st_nxt;
	// Assembled divider ratio
	logic [asp_pkg::DIV_W-1:0] ratio;
	// Bus decode
	logic [5:0]                word_idx;
	logic                      hit;
	logic                      wr_low;
	logic                      wr_high;
	logic                      rd_start;
	// Read-only status word, assembled from registered state
	logic [31:0]               status_word;
	logic                      ramp_active;
	// Per-bit PA block enables
	logic [asp_pkg::PA_W-1:0]  en_a;
	logic [asp_pkg::PA_W-1:0]  en_b;
	// Keying input synchroniser chain
	logic                      ask_s1_r;
	logic                      ask_s2_r;
	logic                      ask_s3_r;
	logic                      ask_lvl_r;

	// Pin input through three flops; change accepted when last two agree
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ask_s1_r  <= 1'b0;
			ask_s2_r  <= 1'b0;
			ask_s3_r  <= 1'b0;
			ask_lvl_r <= 1'b0;
		end else begin
			ask_s1_r <= ask_data_i;
			ask_s2_r <= ask_s1_r;
			ask_s3_r <= ask_s2_r;
			if (ask_s2_r == ask_s3_r) begin
				ask_lvl_r <= ask_s3_r;
			end
		end
	end

	// [RQ1] [RQ2] ratio assembly
	assign ratio = {st_r.pa_slope_hi[asp_pkg::HI_W-1:0], st_r.slope_low};

	// Word address from byte address; low two bits ignored
	assign word_idx = avs_address_i[7:2];
	// Only the low byte lane carries write data; reads ignore byte enables
	assign hit = avs_byteenable_i[0];

	// Write strobes per register; a write never waits, so it lands at once
	assign wr_low  = avs_write_i && hit && (word_idx == asp_pkg::REG_IDX_SLOPE_LOW[5:0]);
	assign wr_high = avs_write_i && hit && (word_idx == asp_pkg::REG_IDX_PA_SLOPE_HI[5:0]);
	// A read is started once; the second cycle only hands out the data
	assign rd_start = avs_read_i && !st_r.rd_valid;

	// Status word: level at 13, step at 12:9, ramp at 8, ratio low byte
	assign ramp_active = (st_r.state == asp_pkg::ASP_RAMP);
	assign status_word = {18'h00000,
		st_r.level,
		st_r.step,
		ramp_active,
		ratio[7:0]};

	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		st_nxt.rd_valid = 1'b0;
		// [RQ1] low ratio byte
		if (wr_low) begin
			st_nxt.slope_low = avs_writedata_i[7:0];
		end
		// [RQ2] [RQ5] high ratio bits and selections
		if (wr_high) begin
			st_nxt.pa_slope_hi = avs_writedata_i[7:0];
		end
		// Reads answer one cycle later; unmapped returns zero
		if (rd_start) begin
			st_nxt.rd_valid = 1'b1;
			unique case (word_idx)
				asp_pkg::REG_IDX_SLOPE_LOW[5:0]: begin
					st_nxt.rd_data = {24'h000000, st_r.slope_low};
				end
				asp_pkg::REG_IDX_PA_SLOPE_HI[5:0]: begin
					st_nxt.rd_data = {24'h000000, st_r.pa_slope_hi};
				end
				asp_pkg::REG_IDX_STATUS[5:0]: begin
					st_nxt.rd_data = status_word;
				end
				default: begin
					st_nxt.rd_data = 32'h00000000;
				end
			endcase
		end
		// [RQ3] [RQ6] [RQ7] reload counter: expiry every ratio+1 cycles
		if (st_r.div_cnt == '0) begin
			st_nxt.div_cnt = ratio;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.div_cnt = st_r.div_cnt - 1'b1;
		end
		// [RQ4] ticks step the PA stage ramp toward the keyed level
		// A level change during a ramp waits until that ramp has finished,
		// so the stages never reverse direction in mid-slope.
		unique case (st_r.state)
			asp_pkg::ASP_IDLE: begin
				// Start a ramp on a new synchronised keying level
				if (ask_lvl_r != st_r.level) begin
					st_nxt.state = asp_pkg::ASP_RAMP;
					st_nxt.level = ask_lvl_r;
				end
			end
			asp_pkg::ASP_RAMP: begin
				// One stage per shaping tick; stop at either end
				if (st_nxt.tick) begin
					if (st_r.level && st_r.step != STEPS[asp_pkg::STEP_W-1:0]) begin
						st_nxt.step = st_r.step + 1'b1;
					end else if (!st_r.level && st_r.step != '0) begin
						st_nxt.step = st_r.step - 1'b1;
					end else begin
						st_nxt.state = asp_pkg::ASP_IDLE;
					end
				end
			end
		endcase
	end

	// State register; reset loads only constants
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= '{
				slope_low:   asp_pkg::RST_SLOPE_LOW,
				pa_slope_hi: asp_pkg::RST_PA_SLOPE_HI,
				div_cnt:     '0,
				tick:        1'b0,
				step:        '0,
				level:       1'b0,
				rd_valid:    1'b0,
				rd_data:     '0,
				state:       asp_pkg::ASP_IDLE
			};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Write never waits; read waits one cycle for the registered data
	assign avs_waitrequest_o = avs_read_i && !st_r.rd_valid;
	assign avs_readdata_o    = st_r.rd_data;
	// [RQ5] bit n enables block n
	for (genvar g = 0; g < asp_pkg::PA_W; g++) begin : g_pa_en
		assign en_a[g] = st_r.pa_slope_hi[asp_pkg::SEL_A_LSB + g];
		assign en_b[g] = st_r.pa_slope_hi[asp_pkg::SEL_B_LSB + g];
	end
	// Enables come straight from registered fields, so they never glitch
	assign pa_block_en_a_o = en_a;
	assign pa_block_en_b_o = en_b;
	assign slope_tick_o    = st_r.tick;
	assign pa_stage_step_o = st_r.step;
endmodule : asp_block
`default_nettype wire

// ==== include/asp_pkg.sv ====
// Package with register map, field layout and reset values for ASK slope / PA block config
package asp_pkg;
	// Offsets are register indices; byte address is four times the index
	localparam logic [7:0] REG_IDX_SLOPE_LOW  = 8'h19;
	localparam logic [7:0] REG_IDX_PA_SLOPE_HI = 8'h1A;
	localparam logic [7:0] REG_IDX_STATUS     = 8'h1D;

	localparam int DIV_W     = 10;
	localparam int LOW_W     = 8;
	localparam int HI_W      = 2;
	localparam int PA_W      = 3;
	localparam int SEL_A_LSB = 2;
	localparam int SEL_B_LSB = 5;
	localparam int STEP_W    = 4;

	// Reset value: bit 7 of low byte set, all else clear
	localparam logic [7:0] RST_SLOPE_LOW   = 8'h80;
	localparam logic [7:0] RST_PA_SLOPE_HI = 8'h00;

	typedef enum logic {
		ASP_IDLE,
		ASP_RAMP
	} asp_state_e;

	typedef struct packed {
		logic [7:0]        slope_low;
		logic [7:0]        pa_slope_hi;
		logic [DIV_W-1:0]  div_cnt;
		logic              tick;
		logic [STEP_W-1:0] step;
		logic              level;
		logic              rd_valid;
		logic [31:0]       rd_data;
		asp_state_e        state;
	} asp_state_s;
endpackage : asp_pkg

// ==== tb/asp_block_properties.sv ====
// Slope block port checker
`timescale 1ns/1ps
`default_nettype none
module asp_block_checker #(parameter int STEPS = 12) (
	input wire logic ref_clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o,
	input wire logic [3:0] pa_stage_step_o,
	input wire logic [2:0] pa_block_en_a_o, pa_block_en_b_o);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Selections only move after a write, one spare stage allowed
	a_en_a: assert property (!avs_write_i [*2] |=> $stable(pa_block_en_a_o)) else $error("a");
	a_en_b: assert property (!avs_write_i [*2] |=> $stable(pa_block_en_b_o)) else $error("b");
	a_rd_wait: assert property ($rose(avs_read_i) |-> avs_waitrequest_o) else $error("w");
	a_rd_done: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("d");
	a_wr_fast: assert property (avs_write_i |-> !avs_waitrequest_o) else $error("f");
	a_step_max: assert property (pa_stage_step_o <= STEPS) else $error("m");
	a_step_one: assert property ($changed(pa_stage_step_o) |->
		(pa_stage_step_o - $past(pa_stage_step_o)) inside {4'h1, 4'hF}) else $error("u");
endmodule : asp_block_checker
bind asp_block asp_block_checker #(.STEPS(STEPS)) u_chk (.*);
`default_nettype wire

// ==== tb/asp_block_tb.sv ====
// Slope block bench
`timescale 1ns/1ps
`default_nettype none
module asp_block_tb;
	logic ref_clk_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0, ask_data_i = 0;
	logic [7:0] avs_address_i = '0, d;
	logic [31:0] avs_writedata_i = '0, avs_readdata_o;
	logic [3:0] avs_byteenable_i = 4'h1, pa_stage_step_o;
	logic [2:0] pa_block_en_a_o, pa_block_en_b_o;
	logic [9:0] r;
	logic [31:0] rd;
	logic avs_waitrequest_o, slope_tick_o;
	int miscompares = 0, samples_checked = 0, n;
	asp_block #(.STEPS(4)) DUT (.*);
	initial forever #4 ref_clk_i = ~ref_clk_i;
	// Hang guard
	initial begin
		#600us miscompares++;
		stop_test;
	end
	task automatic chk(string s, logic [31:0] e, v);
		samples_checked++;
		miscompares += v !== e;
		if (v !== e) $display("MISMATCH %s %h %h", s, e, v);
	endtask : chk
	// Held until waitrequest low
	task automatic bus(logic w, logic [7:0] a, x);
		avs_address_i <= a;
		avs_writedata_i <= {24'h0, x};
		{avs_write_i, avs_read_i} <= {w, !w};
		do @(posedge ref_clk_i); while (avs_waitrequest_o);
		rd = avs_readdata_o;
		{avs_write_i, avs_read_i} <= 2'h0;
		@(posedge ref_clk_i);
	endtask : bus
	task automatic stop_test;
		if (!miscompares && samples_checked) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test
	initial begin
		void'($urandom(28233));
		repeat (8) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		bus(0, 8'h64, 8'h00);
		chk("low", 32'h80, rd);
		for (int i = 0; i < 6; i++) begin
			r = i < 2 ? {10{i[0]}} : 10'($urandom);
			d = {6'($urandom), r[9:8]};
			bus(1, 8'h64, r[7:0]);
			bus(1, 8'h68, d);
			chk("en", d[7:2], {pa_block_en_b_o, pa_block_en_a_o});
			bus(0, 8'h64, 8'h00);
			chk("rlow", r[7:0], rd);
			bus(0, 8'h68, 8'h00);
			chk("rhigh", d, rd);
			bus(0, 8'h74, 8'h00);
			chk("stat", r[7:0], rd[7:0]);
			repeat (2) begin
				@(posedge ref_clk_i);
				for (n = 1; !slope_tick_o; n++) @(posedge ref_clk_i);
			end
			chk("per", r + 1, n);
		end
		avs_byteenable_i <= 4'h0;
		bus(1, 8'h68, 8'hFF);
		avs_byteenable_i <= 4'h1;
		chk("en_hold", d[7:2], {pa_block_en_b_o, pa_block_en_a_o});
		ask_data_i <= 1'b1;
		repeat (9000) @(posedge ref_clk_i);
		chk("step", 32'h4, pa_stage_step_o);
		stop_test;
	end
endmodule : asp_block_tb
`default_nettype wire
